/* File: iocap_cell.sv */
/*
 * Input side of a programmable I/O cell: direct path, transparent latch,
 * single-rate input register and double-data-rate register pair, with a
 * selectable input delay, configured and observed over Avalon-MM.
 * Assumes pad, capture clocks and set/reset lines are asynchronous pins;
 * each passes a two-stage synchroniser before use.
 */
// The Avalon-MM register port and the register offsets were decided locally.
// Behaviour
// [RULE1] With the capture clock enable high at a rising first capture clock edge, the register takes the pad value.
// [RULE2] A synchronous set/reset high at a rising capture edge loads the set/reset value at that edge.
// [RULE3] An asynchronous set/reset loads the set/reset value at once, with no capture edge needed.
// [RULE4] The chip-wide global set/reset forces the registered output to its set/reset value.
// [RULE5] A transparent latch path, gated by the first capture clock, can feed the registered output.
// [RULE6] A selectable delay element sits in front of the direct output and the register or latch input.
// [RULE7] In double-data-rate mode the first register samples on the first clock and the second on the second.
// [RULE8] Outside logic changes the shared enable and pad input only between the two capture clock edges.
// [RULE9] In double-data-rate mode a synchronous reset clears each register at its own next capture edge.
// [RULE10] With the capture clock enable low at a capture edge the register keeps its value.
`timescale 1ns/1ps
`include "iocap_map.svh"

module iocap_cell #(
   parameter int DELAY_TAPS = `IOCAP_DELAY_TAPS
) (
   input wire logic clk_in, // system clock, 20 MHz
   input wire logic rst_in, // asynchronous reset, active high
   input wire logic pad_in, // pad signal
   input wire logic capture_clock_first_in, // first capture clock pin
   input wire logic capture_clock_second_in, // second capture clock pin
   input wire logic capture_clock_enable_in, // shared capture enable
   input wire logic cell_set_reset_in, // cell set/reset
   input wire logic global_set_reset_in, // chip-wide set/reset
   input wire logic [3:0] address_in, // avalon byte address
   input wire logic read_in, // avalon read
   input wire logic write_in, // avalon write
   input wire logic [31:0] writedata_in, // avalon write data
   output logic [31:0] readdata_out, // avalon read data
   output logic waitrequest_out, // avalon wait request
   output logic direct_out, // direct path output
   output logic registered_in_out_out, // register or latch output
   output logic ddr_out_first_out, // first ddr register output
   output logic ddr_out_second_out // second ddr register output
);
   import iocap_pkg::*;

   // ----------------------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------------------
   if (DELAY_TAPS < 1) begin : g_bad_taps
      $error("DELAY_TAPS must be at least 1");
   end

   // ----------------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------------
   localparam int PIN_COUNT = 6;
   localparam int PIN_PAD = 0;
   localparam int PIN_CLK1 = 1;
   localparam int PIN_CLK2 = 2;
   localparam int PIN_CE = 3;
   localparam int PIN_SR = 4;
   localparam int PIN_GSR = 5;

   logic [PIN_COUNT-1:0] pin_meta;
   logic [PIN_COUNT-1:0] pin_sync;
   logic clk1_prev;
   logic clk2_prev;
   wire logic [PIN_COUNT-1:0] pin_bus = {global_set_reset_in, cell_set_reset_in, capture_clock_enable_in,
                                         capture_clock_second_in, capture_clock_first_in, pad_in};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_meta <= '0;
         pin_sync <= '0;
         clk1_prev <= 1'b0;
         clk2_prev <= 1'b0;
      end else begin
         pin_meta <= pin_bus;
         pin_sync <= pin_meta;
         clk1_prev <= pin_sync[PIN_CLK1];
         clk2_prev <= pin_sync[PIN_CLK2];
      end
   end

   wire logic pad_sync = pin_sync[PIN_PAD];
   wire logic gate_first = pin_sync[PIN_CLK1];
   wire logic edge_first = pin_sync[PIN_CLK1] && !clk1_prev;
   wire logic edge_second = pin_sync[PIN_CLK2] && !clk2_prev;
   // [RULE10] enable gates capture
   wire logic ce_sync = pin_sync[PIN_CE];
   wire logic sr_sync = pin_sync[PIN_SR];
   wire logic gsr_sync = pin_sync[PIN_GSR];

   // ----------------------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------------------
   logic [`IOCAP_CFG_WIDTH-1:0] cfg;
   logic [DELAY_TAPS-1:0] delay_line;

   wire iocap_mode_t mode = iocap_mode_t'(cfg[`IOCAP_CFG_MODE_HI:`IOCAP_CFG_MODE_LO]);
   wire logic delay_en = cfg[`IOCAP_CFG_DELAY_BIT];
   wire logic sr_async = cfg[`IOCAP_CFG_ASYNC_BIT];
   wire logic sr_value = cfg[`IOCAP_CFG_SRVAL_BIT];
   wire logic mode_latch = (mode == IOCAP_MODE_LATCH);
   wire logic mode_ddr = (mode == IOCAP_MODE_DDR);

   // ----------------------------------------------------------------------------
   // input delay element
   // ----------------------------------------------------------------------------
   wire logic delay_tap = delay_line[DELAY_TAPS-1];
   // [RULE6] delayed or direct pad
   wire logic data_sel = delay_en ? delay_tap : pad_sync;
   wire logic [DELAY_TAPS-1:0] next_delay_line = DELAY_TAPS'({delay_line, pad_sync});

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         delay_line <= '0;
         direct_out <= 1'b0;
      end else begin
         delay_line <= next_delay_line;
         direct_out <= data_sel;
      end
   end

   // ----------------------------------------------------------------------------
   // capture controls
   // ----------------------------------------------------------------------------
   // [RULE3] asynchronous set/reset acts at once
   // [RULE4] global set/reset overrides capture and synchronous set/reset in all three registers
   wire logic force_level = gsr_sync || (sr_async && sr_sync);
   // [RULE2] synchronous set/reset waits for a strobe
   wire logic sync_clear = sr_sync && !sr_async;
   // [RULE5] latch mode follows the first clock level
   wire logic sample_first = mode_latch ? gate_first : edge_first;
   // [RULE7] second register only runs in ddr mode
   // [RULE8] shared enable and pad assumed settled between edges
   wire logic sample_second = mode_ddr && edge_second;
   // [RULE7] first ddr register on first edges
   wire logic sample_ddr_first = mode_ddr && edge_first;

   // ----------------------------------------------------------------------------
   // storage elements
   // ----------------------------------------------------------------------------
   // [RULE1] first register, also latch; the first ddr output comes from u_ddr_first
   iocap_capture_ff u_first (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .sample_in(sample_first),
      .enable_in(ce_sync),
      .data_in(data_sel),
      .sync_clear_in(sync_clear),
      .force_in(force_level),
      .preset_in(sr_value),
      .q_out(registered_in_out_out)
   );

   // [RULE9] second register resets on its own edge
   iocap_capture_ff u_second (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .sample_in(sample_second),
      .enable_in(ce_sync),
      .data_in(data_sel),
      .sync_clear_in(sync_clear),
      .force_in(force_level),
      .preset_in(sr_value),
      .q_out(ddr_out_second_out)
   );

   // [RULE7] first ddr register
   iocap_capture_ff u_ddr_first (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .sample_in(sample_ddr_first),
      .enable_in(ce_sync),
      .data_in(data_sel),
      .sync_clear_in(sync_clear),
      .force_in(force_level),
      .preset_in(sr_value),
      .q_out(ddr_out_first_out)
   );

   // ----------------------------------------------------------------------------
   // avalon-mm slave
   // ----------------------------------------------------------------------------
   wire logic bus_req = read_in || write_in;
   wire logic next_waitrequest = !(bus_req && waitrequest_out);
   wire logic take_write = write_in && !waitrequest_out;
   wire logic hit_cfg = (address_in == `IOCAP_CFG_OFS);
   wire logic hit_stat = (address_in == `IOCAP_STAT_OFS);
   wire logic [31:0] stat_word = 32'(({3'h0, pad_sync} << `IOCAP_STAT_PAD_BIT)
                                   | ({3'h0, direct_out} << `IOCAP_STAT_DIRECT_BIT)
                                   | ({3'h0, ddr_out_second_out} << `IOCAP_STAT_DDR2_BIT)
                                   | ({3'h0, registered_in_out_out} << `IOCAP_STAT_REG_BIT));
   wire logic [31:0] read_mux = hit_cfg ? 32'(cfg) : (hit_stat ? stat_word : `IOCAP_READ_ZERO);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         waitrequest_out <= 1'b1;
         readdata_out <= `IOCAP_READ_ZERO;
         cfg <= `IOCAP_CFG_RESET;
      end else begin
         waitrequest_out <= next_waitrequest;
         if (read_in && waitrequest_out) begin
            readdata_out <= read_mux;
         end
         if (take_write && hit_cfg) begin
            cfg <= writedata_in[`IOCAP_CFG_WIDTH-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   // [RULE1] enabled edge captures
   chk_reg_capture: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
      (sample_first && !mode_latch && ce_sync && !force_level && !sync_clear)
      |=> (registered_in_out_out == $past(data_sel)))
      else $error("register missed an enabled capture");

   // [RULE2] synchronous set/reset load
   chk_sync_clear: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE2]
      (sample_first && sync_clear && !force_level)
      |=> (registered_in_out_out == $past(sr_value)))
      else $error("register missed a synchronous set/reset");

   // [RULE3] asynchronous set/reset load
   chk_async_force: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE3]
      (sr_async && sr_sync)
      |=> (registered_in_out_out == $past(sr_value)))
      else $error("register missed an asynchronous set/reset");

   // [RULE4] global set/reset load
   chk_global_force: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE4]
      gsr_sync
      |=> (registered_in_out_out == $past(sr_value) && ddr_out_second_out == $past(sr_value)))
      else $error("register missed a global set/reset");

   // [RULE5] open latch follows data
   chk_latch_follow: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
      (mode_latch && gate_first && ce_sync && !force_level && !sync_clear)
      |=> (registered_in_out_out == $past(data_sel)))
      else $error("open latch did not follow its input");

   // [RULE6] undelayed direct path
   chk_direct_path: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE6]
      !delay_en
      |=> (direct_out == $past(pad_sync)))
      else $error("direct output did not follow the pad");

   // [RULE7] second register takes data
   chk_ddr_second_take: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
      (sample_second && ce_sync && !force_level && !sync_clear)
      |=> (ddr_out_second_out == $past(data_sel)))
      else $error("second ddr register missed a capture");

   // [RULE7] first register takes data
   chk_ddr_first_take: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
      (mode_ddr && edge_first && ce_sync && !force_level && !sync_clear)
      |=> (ddr_out_first_out == $past(data_sel)))
      else $error("first ddr register missed a capture");

   // [RULE7] second register idle outside ddr
   chk_ddr_second_idle: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
      (!mode_ddr && !force_level)
      |=> $stable(ddr_out_second_out))
      else $error("second ddr register moved outside ddr mode");

   // [RULE9] second register reset edge
   chk_ddr_second_reset: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE9]
      (sample_second && sync_clear && !force_level)
      |=> (ddr_out_second_out == $past(sr_value)))
      else $error("second ddr register missed its reset edge");

   // [RULE9] first register reset edge
   chk_ddr_first_reset: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE9]
      (mode_ddr && edge_first && sync_clear && !force_level)
      |=> (ddr_out_first_out == $past(sr_value)))
      else $error("first ddr register missed its reset edge");

   // [RULE10] disabled register holds
   chk_enable_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE10]
      (!ce_sync && !force_level && !sync_clear)
      |=> $stable(registered_in_out_out))
      else $error("register changed with its enable low");

   // ----------------------------------------------------------------------------
   // coverage of main scenarios
   // ----------------------------------------------------------------------------
   cov_reg_capture: cover property (@(posedge clk_in) disable iff (rst_in)
      sample_first && !mode_latch && ce_sync);

   cov_latch_open: cover property (@(posedge clk_in) disable iff (rst_in)
      mode_latch && gate_first && ce_sync);

   cov_ddr_second: cover property (@(posedge clk_in) disable iff (rst_in)
      sample_second && ce_sync);

   cov_ddr_reset: cover property (@(posedge clk_in) disable iff (rst_in)
      sample_second && sync_clear);

   cov_global_force: cover property (@(posedge clk_in) disable iff (rst_in)
      gsr_sync);
endmodule : iocap_cell

/* File: iocap_map.svh */
/*
 * Register offsets, field positions, reset values and timing constants of the I/O input capture cell.
 * Assumes byte addressing on a 32-bit Avalon-MM slave port with a 4-bit address.
 */
`ifndef IOCAP_MAP_SVH
`define IOCAP_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define IOCAP_CFG_OFS 4'h0
`define IOCAP_STAT_OFS 4'h4

// ----------------------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------------------
`define IOCAP_CFG_MODE_LO 0
`define IOCAP_CFG_MODE_HI 1
`define IOCAP_CFG_DELAY_BIT 2
`define IOCAP_CFG_ASYNC_BIT 3
`define IOCAP_CFG_SRVAL_BIT 4
`define IOCAP_CFG_WIDTH 5
`define IOCAP_CFG_RESET 5'h00

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define IOCAP_STAT_REG_BIT 0
`define IOCAP_STAT_DDR2_BIT 1
`define IOCAP_STAT_DIRECT_BIT 2
`define IOCAP_STAT_PAD_BIT 3

// ----------------------------------------------------------------------------
// reset values and delay element
// ----------------------------------------------------------------------------
`define IOCAP_Q_RESET 1'b0
`define IOCAP_DELAY_TAPS 4
`define IOCAP_READ_ZERO 32'h0000_0000

`endif

/* File: iocap_pkg.sv */
/*
 * Types shared by the I/O input capture cell files.
 * Assumes nothing of its surroundings.
 */
package iocap_pkg;

   // capture path selection, from the configuration mode field
   typedef enum logic [1:0] {
      IOCAP_MODE_REG,
      IOCAP_MODE_LATCH,
      IOCAP_MODE_DDR
   } iocap_mode_t;

endpackage : iocap_pkg

/* File: iocap_capture_ff.sv */
/*
 * One capture storage element of the I/O cell: clock enable, synchronous
 * set/reset at a sample strobe, and a forced set/reset level that acts at once.
 * Assumes sample, enable, data and set/reset are already in the clk_in domain.
 */
`timescale 1ns/1ps
`include "iocap_map.svh"

module iocap_capture_ff (
   input wire logic clk_in, // system clock
   input wire logic rst_in, // asynchronous reset, active high
   input wire logic sample_in, // capture strobe or latch gate
   input wire logic enable_in, // capture clock enable
   input wire logic data_in, // pad data, delayed or not
   input wire logic sync_clear_in, // synchronous set/reset request
   input wire logic force_in, // asynchronous or global set/reset level
   input wire logic preset_in, // set/reset target value
   output logic q_out // stored value
);

   // ----------------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_out <= `IOCAP_Q_RESET;
      end else if (force_in) begin
         q_out <= preset_in;
      end else if (sample_in && sync_clear_in) begin
         q_out <= preset_in;
      end else if (sample_in && enable_in) begin
         q_out <= data_in;
      end
   end

endmodule : iocap_capture_ff

/* File: iocap_pad_src.sv */
/*
 * Pad source and capture clock pins of the I/O input capture cell.
 * Assumes a free-running clk_in; capture clocks stand still between strobes.
 */
`timescale 1ns/1ps

module iocap_pad_src #(
   parameter int HOLD = 16
) (
   input wire logic clk_in, // system clock
   output logic pad_out, // pad level
   output logic first_out, // first capture clock
   output logic second_out // second capture clock
);
   initial begin
      pad_out = 1'b0;
      first_out = 1'b0;
      second_out = 1'b0;
   end

   task automatic drive(input logic p, input logic a, input logic b);
      @(posedge clk_in);
      pad_out <= p;
      first_out <= a;
      second_out <= b;
      repeat (HOLD) @(posedge clk_in);
   endtask : drive
endmodule : iocap_pad_src

/* File: iocap_cell_tb_top.sv */
/*
 * Self-checking bench of the I/O input capture cell, random and corner cases.
 * Assumes every cell output settles within HOLD clocks of its cause.
 */
`timescale 1ns/1ps
`include "iocap_map.svh"

module iocap_cell_tb_top;
   import iocap_pkg::*;
   localparam int HOLD = 16;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ena = 1'b0, csr = 1'b0, global_set_reset = 1'b0, rd = 1'b0, wr = 1'b0, e = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic pad, c1, c2, dir, rq, d1, d2, wreq;
   logic [7:0] lfsr = 8'h4B;
   int mismatches = 0, n_tests = 0, cycles = 0;

   always #25 clk_in = ~clk_in;

   iocap_pad_src #(.HOLD(HOLD)) u_src (.clk_in(clk_in), .pad_out(pad), .first_out(c1), .second_out(c2));
   iocap_cell u_dut (.clk_in(clk_in), .rst_in(rst_in), .pad_in(pad), .capture_clock_first_in(c1),
      .capture_clock_second_in(c2), .capture_clock_enable_in(ena), .cell_set_reset_in(csr),
      .global_set_reset_in(global_set_reset), .address_in(addr), .read_in(rd), .write_in(wr), .writedata_in(wdata),
      .readdata_out(rdata), .waitrequest_out(wreq), .direct_out(dir), .registered_in_out_out(rq),
      .ddr_out_first_out(d1), .ddr_out_second_out(d2));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] cfg_word(iocap_mode_t m, logic dly, logic asy, logic sv);
      return {27'h0, sv, asy, dly, m};
   endfunction : cfg_word

   function automatic logic [7:0] lfsr_next(logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (exp !== got) begin
         mismatches++;
         $display("unexpected at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask : check

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      @(posedge clk_in);
      while (wreq !== 1'b0) @(posedge clk_in);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   // pad set with clocks low, then one strobe of the chosen clock
   task automatic cap(input logic p, input logic s2);
      u_src.drive(p, 1'b0, 1'b0);
      u_src.drive(p, !s2, s2);
      u_src.drive(p, 1'b0, 1'b0);
   endtask : cap

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (HOLD) @(posedge clk_in);
      bus(1'b0, `IOCAP_CFG_OFS, 32'h0);
      check({27'h0, `IOCAP_CFG_RESET}, q);
      bus(1'b0, 4'h8, 32'h0);
      check(`IOCAP_READ_ZERO, q);
      check(32'(`IOCAP_Q_RESET), 32'(rq));
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         bus(1'b1, `IOCAP_CFG_OFS, cfg_word(IOCAP_MODE_REG, lfsr[2], 1'b0, 1'b0));
         ena <= lfsr[1] | (i == 0);
         cap(lfsr[0], 1'b0);
         if (lfsr[1] || i == 0) e = lfsr[0];
         check(32'(e), 32'(rq));
         check(32'(pad), 32'(dir));
      end
      $display("test capture done");
      for (int sv = 0; sv < 2; sv++) begin
         bus(1'b1, `IOCAP_CFG_OFS, cfg_word(IOCAP_MODE_REG, 1'b0, 1'b0, sv[0]));
         ena <= 1'b1;
         csr <= 1'b1;
         cap(!sv[0], 1'b0);
         csr <= 1'b0;
         check(32'(sv), 32'(rq));
      end
      bus(1'b1, `IOCAP_CFG_OFS, cfg_word(IOCAP_MODE_REG, 1'b0, 1'b1, 1'b0));
      csr <= 1'b1;
      u_src.drive(1'b1, 1'b0, 1'b0);
      check(32'h0, 32'(rq));
      csr <= 1'b0;
      cap(1'b1, 1'b0);
      global_set_reset <= 1'b1;
      u_src.drive(1'b1, 1'b0, 1'b0);
      check(32'h0, 32'(rq));
      bus(1'b0, `IOCAP_STAT_OFS, 32'h0);
      check((32'h1 << `IOCAP_STAT_PAD_BIT) | (32'h1 << `IOCAP_STAT_DIRECT_BIT), q);
      global_set_reset <= 1'b0;
      $display("test set reset done");
      bus(1'b1, `IOCAP_CFG_OFS, cfg_word(IOCAP_MODE_LATCH, 1'b0, 1'b0, 1'b0));
      u_src.drive(1'b0, 1'b1, 1'b0);
      check(32'h0, 32'(rq));
      u_src.drive(1'b1, 1'b1, 1'b0);
      check(32'h1, 32'(rq));
      u_src.drive(1'b0, 1'b0, 1'b0);
      check(32'h1, 32'(rq));
      $display("test latch done");
      bus(1'b1, `IOCAP_CFG_OFS, cfg_word(IOCAP_MODE_DDR, 1'b0, 1'b0, 1'b0));
      bus(1'b0, `IOCAP_CFG_OFS, 32'h0);
      check(cfg_word(IOCAP_MODE_DDR, 1'b0, 1'b0, 1'b0), q);
      cap(1'b1, 1'b0);
      cap(1'b0, 1'b1);
      check(32'h1, 32'(d1));
      check(32'h0, 32'(d2));
      cap(1'b1, 1'b1);
      csr <= 1'b1;
      cap(1'b1, 1'b0);
      check(32'h0, 32'(d1));
      check(32'h1, 32'(d2));
      cap(1'b1, 1'b1);
      csr <= 1'b0;
      check(32'h0, 32'(d2));
      $display("test ddr done");
      test_done();
   end
endmodule : iocap_cell_tb_top
